/* hdl/intc_pkg.sv */
package intc_pkg;

  localparam int ADDR_W = 8;
  localparam int STACK_DEPTH = 8;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [ADDR_W-1:0] OFS_MASTER = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LATCH = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SELECT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

  // Bit positions in the select register.
  localparam int SEL_L14 = 0;
  localparam int SEL_L15 = 1;
  localparam int SEL_EXT0EN = 2;
  localparam int SEL_TRAPOUT = 3;
  localparam int SEL_WATCHDOG_OUTPUT_SELECT = 4;

  // Source indices; from IDX_ATRAP up the index equals the latch bit, from IDX_EXT0 up the enable bit too.
  localparam logic [3:0] IDX_SWI = 4'h1;
  localparam logic [3:0] IDX_ATRAP = 4'h2;
  localparam logic [3:0] IDX_WDT = 4'h3;
  localparam logic [3:0] IDX_EXT0 = 4'h4;
  localparam logic [3:0] IDX_L14 = 4'he;
  localparam logic [3:0] IDX_L15 = 4'hf;

  localparam logic [15:0] MASKABLE_MASK = 16'hfff0;
  localparam logic [15:0] LATCH_MASK = 16'hfffc;
  localparam logic [15:0] VEC_RESET = 16'hfffe;

  // Reset values.
  localparam logic MASTER_RST = 1'b0;
  localparam logic [15:0] ENABLE_RST = 16'h0000;
  localparam logic [15:0] LATCH_RST = 16'h0000;
  localparam logic [4:0] SELECT_RST = 5'h18;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } bus_st_t;

  // Vectors descend by two from the reset vector as the index rises.
  function automatic logic [15:0] vector_of(input logic [3:0] idx);
    vector_of = VEC_RESET - {11'h000, idx, 1'b0};
  endfunction

endpackage

/* hdl/intc_top.sv */
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
module intc_top
  import intc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic SOFTWARE_TRAP_IRQ,
  input wire logic UNDEFINED_OPCODE_IRQ,
  input wire logic ADDRESS_TRAP_IRQ,
  input wire logic WATCHDOG_IRQ,
  input wire logic EXT0_IRQ,
  input wire logic EXT1_IRQ,
  input wire logic TIME_BASE_IRQ,
  input wire logic TIMER1_IRQ,
  input wire logic EXT2_IRQ,
  input wire logic TIMER4_IRQ,
  input wire logic TIMER3_IRQ,
  input wire logic EXT3_IRQ,
  input wire logic SERIAL_SHIFT_IRQ,
  input wire logic UART_RECEIVE_IRQ,
  input wire logic EXT4_IRQ,
  input wire logic UART_TRANSMIT_IRQ,
  input wire logic EXT5_IRQ,
  input wire logic CONVERTER_DONE_IRQ,
  input wire logic IRQ_ACCEPT,
  input wire logic RETURN_FROM_IRQ_OP,
  output logic IRQ_REQUEST,
  output logic [3:0] IRQ_SOURCE,
  output logic [15:0] IRQ_VECTOR,
  output logic MASTER_IRQ_ENABLE,
  output logic MALFUNCTION_RESET_REQ
);

  typedef struct packed {
    logic master_irq_enable;
    logic [15:0] source_enable_flags;
    logic [15:0] pending_latches;
    logic [4:0] shared_level_selector;
    logic [STACK_DEPTH-1:0] ime_stack;
    logic [3:0] stack_depth;
    logic req;
    logic [3:0] idx;
    logic [15:0] vec;
    logic rst_req;
    bus_st_t wst;
    logic aw_have;
    logic w_have;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    bus_st_t rdst;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  localparam state_t STATE_RST = '{
    master_irq_enable: MASTER_RST,
    source_enable_flags: ENABLE_RST,
    pending_latches: LATCH_RST,
    shared_level_selector: SELECT_RST,
    ime_stack: '0,
    stack_depth: 4'h0,
    req: 1'b0,
    idx: 4'h0,
    vec: VEC_RESET,
    rst_req: 1'b0,
    wst: BUS_IDLE,
    aw_have: 1'b0,
    w_have: 1'b0,
    awaddr: '0,
    wdata: 32'h00000000,
    wstrb: 4'h0,
    awready: 1'b1,
    wready: 1'b1,
    bvalid: 1'b0,
    bresp: RESP_OKAY,
    rdst: BUS_IDLE,
    arready: 1'b1,
    rvalid: 1'b0,
    rdata: 32'h00000000,
    rresp: RESP_OKAY
  };

  state_t q;
  state_t d;
  logic [15:0] set_vec;
  logic [15:0] elig_next;
  logic pe_found;
  logic [3:0] pe_idx;
  logic [15:0] pe_vec;
  logic ack;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == OFS_MASTER) || (a == OFS_ENABLE) || (a == OFS_LATCH) ||
                (a == OFS_SELECT) || (a == OFS_STATUS);
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic [31:0] read_mux(input state_t s, input logic [ADDR_W-1:0] a);
    case (a)
      OFS_MASTER: read_mux = {31'h00000000, s.master_irq_enable};
      OFS_ENABLE: read_mux = {16'h0000, s.source_enable_flags};
      OFS_LATCH: read_mux = {16'h0000, s.pending_latches};
      OFS_SELECT: read_mux = {27'h0000000, s.shared_level_selector};
      OFS_STATUS: read_mux = {s.vec, 7'h00, s.req, s.idx, s.stack_depth};
      default: read_mux = 32'h00000000;
    endcase
  endfunction

  // Only the selected member of each shared pair can reach its latch.
  always_comb begin
    set_vec = 16'h0000;
    set_vec[IDX_ATRAP] = ADDRESS_TRAP_IRQ && !q.shared_level_selector[SEL_TRAPOUT];
    set_vec[IDX_WDT] = WATCHDOG_IRQ && !q.shared_level_selector[SEL_WATCHDOG_OUTPUT_SELECT];
    set_vec[IDX_EXT0] = EXT0_IRQ;
    set_vec[5] = EXT1_IRQ;
    set_vec[6] = TIME_BASE_IRQ;
    set_vec[7] = TIMER1_IRQ;
    set_vec[8] = EXT2_IRQ;
    set_vec[9] = TIMER4_IRQ;
    set_vec[10] = TIMER3_IRQ;
    set_vec[11] = EXT3_IRQ;
    set_vec[12] = SERIAL_SHIFT_IRQ;
    set_vec[13] = UART_RECEIVE_IRQ;
    set_vec[IDX_L14] = q.shared_level_selector[SEL_L14] ? UART_TRANSMIT_IRQ : EXT4_IRQ;
    set_vec[IDX_L15] = q.shared_level_selector[SEL_L15] ? CONVERTER_DONE_IRQ : EXT5_IRQ;
  end

  assign ack = IRQ_ACCEPT && q.req;

  always_comb begin
    logic [31:0] merged;
    logic [15:0] sw_clr;
    logic [15:0] ack_clr;
    logic [15:0] masked_ok;
    logic [31:0] lanes;
    merged = 32'h00000000;
    sw_clr = 16'h0000;
    ack_clr = 16'h0000;
    masked_ok = 16'h0000;
    lanes = 32'h00000000;
    d = q;

    if (q.wst == BUS_IDLE) begin
      if (AWVALID && q.awready) begin
        d.aw_have = 1'b1;
        d.awaddr = AWADDR;
      end
      if (WVALID && q.wready) begin
        d.w_have = 1'b1;
        d.wdata = WDATA;
        d.wstrb = WSTRB;
      end
      if (d.aw_have && d.w_have) begin
        // Only strobed lanes may take part in a write or in a latch clear.
        lanes = lane_mask(d.wstrb);
        merged = (read_mux(q, d.awaddr) & ~lanes) | (d.wdata & lanes);
        case (d.awaddr)
          OFS_MASTER: d.master_irq_enable = merged[0];
          OFS_ENABLE: d.source_enable_flags = merged[15:0] & MASKABLE_MASK;
          OFS_LATCH: sw_clr = ~d.wdata[15:0] & lanes[15:0] & LATCH_MASK;
          OFS_SELECT: d.shared_level_selector = merged[4:0];
          default: merged = 32'h00000000;
        endcase
        d.bresp = is_mapped(d.awaddr) ? RESP_OKAY : RESP_SLVERR;
        d.bvalid = 1'b1;
        d.aw_have = 1'b0;
        d.w_have = 1'b0;
        d.wst = BUS_RESP;
      end
    end else if (BREADY) begin
      d.bvalid = 1'b0;
      d.wst = BUS_IDLE;
    end
    d.awready = (d.wst == BUS_IDLE) && !d.aw_have;
    d.wready = (d.wst == BUS_IDLE) && !d.w_have;

    if (q.rdst == BUS_IDLE) begin
      if (ARVALID) begin
        d.rdata = read_mux(q, ARADDR);
        d.rresp = is_mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
        d.rvalid = 1'b1;
        d.rdst = BUS_RESP;
      end
    end else if (RREADY) begin
      d.rvalid = 1'b0;
      d.rdst = BUS_IDLE;
    end
    d.arready = (d.rdst == BUS_IDLE);

    // Accepting clears the latch of the source shown to the CPU on the clock edge that ends the accept cycle.
    if (ack) begin
      ack_clr = (16'h0001 << q.idx) & LATCH_MASK;
      d.ime_stack = {q.ime_stack[STACK_DEPTH-2:0], q.master_irq_enable};
      d.stack_depth = (q.stack_depth == 4'(STACK_DEPTH)) ? q.stack_depth : q.stack_depth + 4'h1;
      d.master_irq_enable = 1'b0;
    end else if (RETURN_FROM_IRQ_OP) begin
      d.master_irq_enable = q.ime_stack[0];
      d.ime_stack = {1'b0, q.ime_stack[STACK_DEPTH-1:1]};
      d.stack_depth = (q.stack_depth == 4'h0) ? 4'h0 : q.stack_depth - 4'h1;
    end

    // A new request in the same cycle as a clear keeps the latch set.
    d.pending_latches = ((q.pending_latches & ~sw_clr & ~ack_clr) | set_vec) & LATCH_MASK;

    masked_ok = d.source_enable_flags & MASKABLE_MASK & {16{d.master_irq_enable}};
    masked_ok[IDX_EXT0] = masked_ok[IDX_EXT0] && d.shared_level_selector[SEL_EXT0EN];
    elig_next = d.pending_latches & (masked_ok | ~MASKABLE_MASK);
    elig_next[IDX_SWI] = (SOFTWARE_TRAP_IRQ || UNDEFINED_OPCODE_IRQ) && !ack;

    d.req = pe_found;
    d.idx = pe_idx;
    d.vec = pe_vec;
    d.rst_req = (ADDRESS_TRAP_IRQ && d.shared_level_selector[SEL_TRAPOUT]) ||
                (WATCHDOG_IRQ && d.shared_level_selector[SEL_WATCHDOG_OUTPUT_SELECT]);
  end

  prio_pick u_pick (
    .eligible(elig_next),
    .found(pe_found),
    .idx(pe_idx),
    .vector(pe_vec)
  );

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign AWREADY = q.awready;
  assign WREADY = q.wready;
  assign BVALID = q.bvalid;
  assign BRESP = q.bresp;
  assign ARREADY = q.arready;
  assign RVALID = q.rvalid;
  assign RDATA = q.rdata;
  assign RRESP = q.rresp;
  assign IRQ_REQUEST = q.req;
  assign IRQ_SOURCE = q.idx;
  assign IRQ_VECTOR = q.vec;
  assign MASTER_IRQ_ENABLE = q.master_irq_enable;
  assign MALFUNCTION_RESET_REQ = q.rst_req;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  logic [15:0] below_win;
  assign below_win = elig_next & ((16'h0001 << pe_idx) - 16'h0001);

  a_latch_sets: assert property (set_vec[7] |=> q.pending_latches[7])
    else $error("pending latch did not set on request");
  a_accept_clears: assert property (ack && q.idx >= IDX_ATRAP && !set_vec[q.idx]
                                    |=> !q.pending_latches[$past(q.idx)])
    else $error("accepted latch still set");
  a_accept_stacks: assert property (ack |=> !q.master_irq_enable && q.ime_stack[0] == $past(q.master_irq_enable))
    else $error("master enable not stacked and cleared on accept");
  a_return_restores: assert property (RETURN_FROM_IRQ_OP && !ack
                                      |=> q.master_irq_enable == $past(q.ime_stack[0]))
    else $error("return did not restore master enable");
  a_mask_gate: assert property (q.req && q.idx >= IDX_EXT0
                                |-> q.master_irq_enable && q.source_enable_flags[q.idx] && q.pending_latches[q.idx])
    else $error("maskable source presented while disabled");
  a_ext0_pin: assert property (q.req && q.idx == IDX_EXT0 |-> q.shared_level_selector[SEL_EXT0EN]
                               && q.vec == 16'hfff6)
    else $error("ext0 presented without pin enable or wrong vector");
  a_lowest_wins: assert property (pe_found |-> below_win == 16'h0000)
    else $error("a higher priority eligible source was skipped");
  a_no_sw_set: assert property (##1 (q.pending_latches & ~$past(q.pending_latches) & ~$past(set_vec)) == 16'h0000)
    else $error("latch rose without a request");
  a_shared_select: assert property (!q.shared_level_selector[SEL_L14] && !EXT4_IRQ && !q.pending_latches[IDX_L14]
                                    |=> !q.pending_latches[IDX_L14])
    else $error("unselected shared source set the latch");
  a_top_vector: assert property (q.req && q.idx == IDX_L15 |-> q.vec == 16'hffe0)
    else $error("level fifteen vector wrong");
  a_trap_vector: assert property (q.req && q.idx == IDX_SWI |-> q.vec == 16'hfffc ##1 1'b1)
    else $error("software trap vector wrong");


  // In reset mode a watchdog overflow must leave its latch alone.
  a_wdt_reset_mode: assert property (q.shared_level_selector[SEL_WATCHDOG_OUTPUT_SELECT] && !q.pending_latches[IDX_WDT]
                                     |=> !q.pending_latches[IDX_WDT])
    else $error("watchdog latch set while in reset mode");
  a_trap_no_latch: assert property (q.pending_latches[1:0] == 2'b00)
    else $error("software trap latch bits not zero");

  c_nested: cover property (ack && q.stack_depth != 4'h0);
  c_uart_tx: cover property (ack && q.idx == IDX_L14 && q.shared_level_selector[SEL_L14]);
  c_trap_accept: cover property (ack && q.idx == IDX_SWI);
  c_bus_error: cover property (q.bvalid && q.bresp == RESP_SLVERR);

endmodule // intc_top

/* hdl/prio_pick.sv */
module prio_pick
  import intc_pkg::*;
(
  input wire logic [15:0] eligible,
  output logic found,
  output logic [3:0] idx,
  output logic [15:0] vector
);

  // Scanning from the top lets the lowest index, the highest priority, win.
  always_comb begin
    found = 1'b0;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (eligible[i]) begin
        found = 1'b1;
        idx = 4'(i);
      end
    end
    vector = vector_of(idx);
  end

endmodule // prio_pick

/* verif/cpu_model.sv */
module cpu_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic irq_request,
  input wire logic [15:0] irq_vector,
  input wire logic go,
  input wire logic [1:0] lag,
  output logic irq_accept,
  output logic [7:0] n_taken,
  output logic [15:0] last_vec
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] hold_q;
  logic [1:0] wait_q;
  // A quiet spell after each accept lets the presentation settle before the next look.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_accept <= 1'b0;
      n_taken <= 8'h00;
      last_vec <= 16'h0000;
      hold_q <= 3'h0;
      wait_q <= 2'h0;
    end else begin
      irq_accept <= 1'b0;
      if (hold_q != 3'h0) begin
        hold_q <= hold_q - 3'h1;
      end else if (go && irq_request === 1'b1) begin
        if (wait_q != lag) begin
          wait_q <= wait_q + 2'h1;
        end else begin
          irq_accept <= 1'b1;
          last_vec <= irq_vector;
          n_taken <= n_taken + 8'h01;
          hold_q <= 3'h4;
          wait_q <= 2'h0;
        end
      end
    end
  end
endmodule // cpu_model

/* verif/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import intc_pkg::*;
  logic SYS_CLK = 0, RST_N = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic sw = 0, ud = 0, ret = 0, go = 0, seen_rst = 0;
  logic [7:0] AWADDR = 0, ARADDR = 0, n_taken;
  logic [31:0] WDATA = 0, RDATA;
  logic [15:0] src = 0, last_vec, IRQ_VECTOR;
  logic [1:0] lag = 0, BRESP, RRESP;
  logic [3:0] IRQ_SOURCE;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ_REQUEST, acc, MASTER_IRQ_ENABLE, rst_req;
  int mismatches = 0, n_compared = 0, cyc = 0;
  intc_top u_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY), .SOFTWARE_TRAP_IRQ(sw), .UNDEFINED_OPCODE_IRQ(ud),
    .ADDRESS_TRAP_IRQ(src[2]), .WATCHDOG_IRQ(src[3]), .EXT0_IRQ(src[4]), .EXT1_IRQ(src[5]),
    .TIME_BASE_IRQ(src[6]), .TIMER1_IRQ(src[7]), .EXT2_IRQ(src[8]), .TIMER4_IRQ(src[9]), .TIMER3_IRQ(src[10]),
    .EXT3_IRQ(src[11]), .SERIAL_SHIFT_IRQ(src[12]), .UART_RECEIVE_IRQ(src[13]), .EXT4_IRQ(src[14]),
    .UART_TRANSMIT_IRQ(src[0]), .EXT5_IRQ(src[15]), .CONVERTER_DONE_IRQ(src[1]), .IRQ_ACCEPT(acc),
    .RETURN_FROM_IRQ_OP(ret), .IRQ_REQUEST(IRQ_REQUEST), .IRQ_SOURCE(IRQ_SOURCE), .IRQ_VECTOR(IRQ_VECTOR),
    .MASTER_IRQ_ENABLE(MASTER_IRQ_ENABLE), .MALFUNCTION_RESET_REQ(rst_req));
  cpu_model u_cpu (.clk(SYS_CLK), .rst_n(RST_N), .irq_request(IRQ_REQUEST), .irq_vector(IRQ_VECTOR), .go(go),
    .lag(lag), .irq_accept(acc), .n_taken(n_taken), .last_vec(last_vec));
  initial begin
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (rst_req === 1'b1) seen_rst <= 1'b1;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge SYS_CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1;
    WVALID <= 1;
    BREADY <= 1;
    while (!aw || !w) begin
      @(posedge SYS_CLK);
      if (!aw && AWREADY === 1'b1) begin
        aw = 1;
        AWVALID <= 0;
      end
      if (!w && WREADY === 1'b1) begin
        w = 1;
        WVALID <= 0;
      end
    end
    do @(posedge SYS_CLK); while (BVALID !== 1'b1);
    BREADY <= 0;
    chk("bresp", 32'(RESP_OKAY), 32'(BRESP));
  endtask
  // Offsets past the status word are unmapped and must answer with an error.
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    @(posedge SYS_CLK);
    ARADDR <= a;
    ARVALID <= 1;
    RREADY <= 1;
    do @(posedge SYS_CLK); while (ARREADY !== 1'b1);
    ARVALID <= 0;
    while (RVALID !== 1'b1) @(posedge SYS_CLK);
    RREADY <= 0;
    chk("rdata", e, RDATA & m);
    chk("rresp", 32'(a > OFS_STATUS ? RESP_SLVERR : RESP_OKAY), 32'(RRESP));
  endtask
  task automatic pulse(input logic [15:0] m);
    @(posedge SYS_CLK);
    src <= m;
    @(posedge SYS_CLK);
    src <= 16'h0000;
  endtask
  task automatic wait_take(input logic [15:0] e);
    logic [7:0] c;
    c = n_taken;
    do @(posedge SYS_CLK); while (n_taken === c);
    chk("vector", {16'h0000, e}, {16'h0000, last_vec});
  endtask
  task automatic ret_pulse;
    @(posedge SYS_CLK);
    ret <= 1;
    @(posedge SYS_CLK);
    ret <= 0;
  endtask
  initial begin
    repeat (5) @(posedge SYS_CLK);
    RST_N <= 1;
    rd(OFS_MASTER, 32'h0);
    rd(OFS_ENABLE, 32'h0);
    rd(OFS_LATCH, 32'h0);
    rd(OFS_SELECT, 32'h18);
    rd(OFS_STATUS, 32'hfffe0000);
    rd(8'h14, 32'h0);
    pulse(16'h0008);
    rd(OFS_LATCH, 32'h0);
    chk("reset_req", 32'h1, {31'h0, seen_rst});
    $display("test reset done");
    pulse(16'h0080);
    rd(OFS_LATCH, 32'h80);
    wr(OFS_ENABLE, 32'h80);
    chk("request", 32'h0, {31'h0, IRQ_REQUEST});
    go <= 1;
    wr(OFS_MASTER, 32'h1);
    wait_take(16'hfff0);
    rd(OFS_LATCH, 32'h0);
    rd(OFS_MASTER, 32'h0);
    ret_pulse();
    rd(OFS_MASTER, 32'h1);
    chk("master_pin", 32'h1, {31'h0, MASTER_IRQ_ENABLE});
    $display("test gating done");
    go <= 0;
    wr(OFS_SELECT, 32'h04);
    wr(OFS_ENABLE, 32'hfff0);
    pulse(16'hfff0);
    @(posedge SYS_CLK);
    chk("irq_source", 32'h4, {28'h0, IRQ_SOURCE});
    chk("irq_vector", 32'hfff6, {16'h0, IRQ_VECTOR});
    go <= 1;
    for (int i = 4; i < 16; i++) begin
      lag <= 2'(i);
      wait_take(16'hfffe - 16'(2 * i));
      if (i < 15) wr(OFS_MASTER, 32'h1);
    end
    ret_pulse();
    rd(OFS_MASTER, 32'h1);
    rd(OFS_STATUS, 32'h7, 32'h1ff);
    $display("test priority done");
    go <= 0;
    wr(OFS_MASTER, 32'h0);
    wr(OFS_SELECT, 32'h07);
    pulse(16'hc000);
    rd(OFS_LATCH, 32'h0);
    pulse(16'h0003);
    rd(OFS_LATCH, 32'hc000);
    wr(OFS_LATCH, 32'hffffffff);
    rd(OFS_LATCH, 32'hc000);
    wr(OFS_LATCH, 32'h3fff);
    rd(OFS_LATCH, 32'h0);
    $display("test shared done");
    go <= 1;
    sw <= 1;
    wait_take(16'hfffc);
    sw <= 0;
    ud <= 1;
    wait_take(16'hfffc);
    ud <= 0;
    pulse(16'h0004);
    wait_take(16'hfffa);
    pulse(16'h0008);
    wait_take(16'hfff8);
    $display("test non-maskable done");
    stop_test();
  end
endmodule // tb
